//--- isp_pkg.sv
// Purpose: shared constants and types of the inertial stream packet framer
// Assumes: 20 MHz system clock, one update tick per millisecond
// Notes:   framing codes, flag bit positions, flag and divider reset values and timing counts live here
package isp_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = TICK_US * CYC_PER_US;
  localparam int TX_DELAY_TICKS = 3;

  // packet framing
  localparam logic [7:0] START_BYTE = 8'ha5;
  localparam logic [7:0] TYPE_INC   = 8'h03;
  localparam logic [7:0] TYPE_MAG   = 8'h04;
  localparam logic [4:0] LEN_INC    = 5'h13;
  localparam logic [4:0] LEN_MAG    = 5'h15;

  // flag byte layout
  localparam int         FLAG_S      = 4;
  localparam int         FLAG_F      = 3;
  localparam int         FLAG_IDX_LO = 0;
  localparam logic [7:0] FLAG_RESET  = 8'h00;

  // rate divider
  localparam logic [7:0] DIV_RESET = 8'h05;
  localparam logic [7:0] DIV_MIN   = 8'h04;

  // arithmetic
  localparam int          RAW_W       = 24;
  localparam int          ACC_W       = 32;
  localparam int          FRAC_BITS   = 8;
  localparam int          ALIGN_SHIFT = 15;
  localparam logic [15:0] LAT_MAX     = 16'h7fff;

  // packet contents carried from snapshot to serialiser
  typedef struct packed {
    logic [7:0]        ptype;
    logic [7:0]        seq;
    logic [7:0]        flags;
    logic [15:0]       latency;
    logic [2:0][15:0]  dv;
    logic [2:0][15:0]  dth;
    logic [15:0]       mag;
  } isp_pkt_t;

  // latest fresh magnetometer sample
  typedef struct packed {
    logic        valid;
    logic [1:0]  axis;
    logic [15:0] value;
  } isp_mag_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } isp_state_t;

endpackage : isp_pkg

//--- isp_fifo.sv
// Purpose: byte buffer between packet serialiser and output stage
// Assumes: depth is a power of two
// Notes:   flop storage, honest full and empty, ready stalls the writer
`timescale 1ns/10ps
module isp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock, reset, enable
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  input  wire logic         i_enable,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);

  logic [D-1:0][W-1:0] mem_q, mem_d;
  logic [AW-1:0]       wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]         cnt_q, cnt_d;
  logic                push, pop;

  // status and read port
  assign o_in_ready  = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    case ({push, pop})
      2'b10:   cnt_d = cnt_q + 1'b1;
      2'b01:   cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  // register stage
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q <= '0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_enable) begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : isp_fifo

//--- isp_framer.sv
// Purpose: builds streamed increment packets of an inertial module
// Assumes: raw increments and flags come from logic on i_clock
// Notes:   bytes leave through an 8-word buffer and a registered port
//
// Notes on behaviour
// [RULE1] latency field is signed 16-bit microseconds since period end
// [RULE2] packet launched at third update tick after its period ends
// [RULE3] frame counter advances once per 256 packets
// [RULE4] rotation increment is signed 16-bit, 0.00625 mrad per count
// [RULE5] rotation truncation remainder carried into next packet
// [RULE6] velocity increment is signed 16-bit, 39.0625e-6 m/s per count
// [RULE7] velocity truncation remainder carried into next packet
// [RULE8] axis index 1..3 with fresh magnetometer data, else index and value 0
// [RULE9] magnetic value signed 16-bit, 0.25e-3 gauss per count
// [RULE10] axis index sits in flag byte bits 1:0, packet byte 3
// [RULE11] flag bit 4 replays config bit n, n being the sequence number
// [RULE12] flag bit 3 set when any runtime warning is active
// [RULE13] flag bits 7,6,5,2 driven to a fixed zero
// [RULE14] increments multiplied by a 3x3 alignment matrix scaled 1/32768
// [RULE15] one layout at a time, increment layout is the default
// [RULE16] bytes 0-3: start 0xa5, type code, sequence, flags
// [RULE17] layout 3: latency, velocity, rotation low first, checksum byte 18
// [RULE18] layout 4 adds magnetic value in bytes 18 and 19, type 4
// [RULE19] host keeps output rate at least 100 Hz for high dynamics
// [RULE20] sequence number is 8-bit position in frame, wraps to zero
// [RULE21] checksum makes all packet bytes sum to zero modulo 256
// [RULE22] update runs at 1000 Hz, packets every divider ticks, default 5; dividers below 4 give packets every 4 ticks
// [RULE23] layout 4 ends with checksum byte 20 over bytes 0-19
// [RULE24] dropped packets still advance sequence and carry remainders
`timescale 1ns/10ps
module isp_framer #(
  parameter int P_TICK_CYCLES = isp_pkg::TICK_CYCLES,
  parameter int P_FIFO_DEPTH  = 8
) (
  // clock, reset, enable
  input  wire logic                   i_clock,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_enable,
  // configuration
  input  wire logic [7:0]             i_rate_divider,
  input  wire logic                   i_layout_mag,
  input  wire logic [8:0][15:0]       i_align,
  input  wire logic [255:0]           i_config_bits,
  input  wire logic [7:0]             i_warn_flags,
  // per-tick raw increments, 1/256 count units
  input  wire logic [2:0][23:0]       i_dv_raw,
  input  wire logic [2:0][23:0]       i_dth_raw,
  // magnetometer sample
  input  wire logic                   i_mag_valid,
  input  wire logic [1:0]             i_mag_axis,
  input  wire logic [15:0]            i_mag_value,
  // byte stream
  output logic                        o_byte_valid,
  output logic [7:0]                  o_byte_data,
  input  wire logic                   i_byte_ready,
  // status
  output logic                        o_update_tick,
  output logic                        o_packet_dropped,
  output logic [7:0]                  o_packet_sequence,
  output logic [15:0]                 o_frame_counter
);
  localparam int TW = $clog2(P_TICK_CYCLES);
  localparam int PW = $clog2(isp_pkg::CYC_PER_US);
  localparam int RW = isp_pkg::RAW_W;
  localparam int AC = isp_pkg::ACC_W;
  localparam int FB = isp_pkg::FRAC_BITS;

  // one row of the alignment product, rescaled by 1/32768
  function automatic logic [RW-1:0] align_row(
    input logic [8:0][15:0] m,
    input int               row,
    input logic [2:0][RW-1:0] v
  );
    logic signed [RW+17:0] s;
    s = '0;
    for (int j = 0; j < 3; j++) begin
      s = s + (RW+18)'($signed(m[row*3+j]) * $signed(v[j]));
    end
    return RW'(s >>> isp_pkg::ALIGN_SHIFT);
  endfunction : align_row

  // packet length by type code
  function automatic logic [4:0] pkt_len(input logic [7:0] t);
    return (t == isp_pkg::TYPE_MAG) ? isp_pkg::LEN_MAG : isp_pkg::LEN_INC;
  endfunction : pkt_len

  // byte at a position of the packet body, checksum excluded
  function automatic logic [7:0] pkt_byte(
    input isp_pkg::isp_pkt_t p,
    input logic [4:0]        idx
  );
    logic [7:0] b;
    case (idx)
      5'h00:   b = isp_pkg::START_BYTE;
      5'h01:   b = p.ptype;
      5'h02:   b = p.seq;
      5'h03:   b = p.flags;
      5'h04:   b = p.latency[7:0];
      5'h05:   b = p.latency[15:8];
      5'h06:   b = p.dv[0][7:0];
      5'h07:   b = p.dv[0][15:8];
      5'h08:   b = p.dv[1][7:0];
      5'h09:   b = p.dv[1][15:8];
      5'h0a:   b = p.dv[2][7:0];
      5'h0b:   b = p.dv[2][15:8];
      5'h0c:   b = p.dth[0][7:0];
      5'h0d:   b = p.dth[0][15:8];
      5'h0e:   b = p.dth[1][7:0];
      5'h0f:   b = p.dth[1][15:8];
      5'h10:   b = p.dth[2][7:0];
      5'h11:   b = p.dth[2][15:8];
      5'h12:   b = p.mag[7:0];
      5'h13:   b = p.mag[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : pkt_byte

  // ---------------------------------------------------------------
  // update tick divider
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic          tick_q, tick_d;

  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 1'b1;
    if (tick_cnt_q == TW'(P_TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1; // [RULE22]
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (i_enable) begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // aligned increments, one per axis
  logic [2:0][RW-1:0] al_dv, al_dth;

  for (genvar a = 0; a < 3; a++) begin : g_align
    assign al_dv[a]  = align_row(i_align, a, i_dv_raw);  // [RULE14]
    assign al_dth[a] = align_row(i_align, a, i_dth_raw); // [RULE14]
  end

  // ---------------------------------------------------------------
  // integration, snapshot and launch timing
  logic [2:0][AC-1:0] acc_dv_q, acc_dv_d, acc_dth_q, acc_dth_d;
  logic [7:0]         per_q, per_d, div_q, div_d, seq_q, seq_d;
  logic [15:0]        frame_q, frame_d, lat_q, lat_d;
  logic [PW-1:0]      pre_q, pre_d;
  logic [1:0]         dly_q, dly_d;
  logic               layout_q, layout_d, pend_q, pend_d;
  logic               drop_q, drop_d, launch;
  isp_pkg::isp_mag_t  mag_q, mag_d;
  isp_pkg::isp_pkt_t  snap_q, snap_d;
  isp_pkg::isp_state_t st_q;

  always_comb begin
    logic [AC-1:0] sdv, sdth;
    sdv       = '0;
    sdth      = '0;
    acc_dv_d  = acc_dv_q;
    acc_dth_d = acc_dth_q;
    per_d     = per_q;
    div_d     = div_q;
    seq_d     = seq_q;
    frame_d   = frame_q;
    layout_d  = layout_q;
    pend_d    = pend_q;
    dly_d     = dly_q;
    snap_d    = snap_q;
    mag_d     = mag_q;
    drop_d    = 1'b0;
    // microsecond clock for the latency field
    pre_d     = pre_q + 1'b1;
    lat_d     = lat_q;
    if (pre_q == PW'(isp_pkg::CYC_PER_US - 1)) begin
      pre_d = '0;
      if (lat_q != isp_pkg::LAT_MAX) begin
        lat_d = lat_q + 16'h0001; // [RULE1]
      end
    end
    launch = tick_q && pend_q &&
             (dly_q == 2'(isp_pkg::TX_DELAY_TICKS - 1));
    if (tick_q && pend_q) begin
      dly_d = dly_q + 2'h1;
    end
    if (launch) begin
      pend_d = 1'b0;               // [RULE2]
      drop_d = (st_q != isp_pkg::ST_IDLE);
    end
    if (tick_q) begin
      per_d = per_q + 8'h01;
      for (int a = 0; a < 3; a++) begin
        sdv  = acc_dv_q[a] + {{(AC-RW){al_dv[a][RW-1]}}, al_dv[a]};
        sdth = acc_dth_q[a] + {{(AC-RW){al_dth[a][RW-1]}}, al_dth[a]};
        acc_dv_d[a]  = sdv;
        acc_dth_d[a] = sdth;
        if (per_d >= div_q) begin
          snap_d.dv[a]  = sdv[FB+15:FB];                // [RULE6]
          snap_d.dth[a] = sdth[FB+15:FB];               // [RULE4]
          acc_dv_d[a]   = {{(AC-FB){1'b0}}, sdv[FB-1:0]};  // [RULE7]
          acc_dth_d[a]  = {{(AC-FB){1'b0}}, sdth[FB-1:0]}; // [RULE5]
        end
      end
      // period end: freeze contents, advance sequence regardless
      if (per_d >= div_q) begin
        per_d         = 8'h00;
        pend_d        = 1'b1;
        dly_d         = 2'h0;
        pre_d         = '0;
        lat_d         = 16'h0000;
        snap_d.ptype  = layout_q ? isp_pkg::TYPE_MAG
                                 : isp_pkg::TYPE_INC; // [RULE15]
        snap_d.seq    = seq_q;                        // [RULE16]
        snap_d.flags  = isp_pkg::FLAG_RESET;          // [RULE13]
        snap_d.flags[isp_pkg::FLAG_S] = i_config_bits[seq_q]; // [RULE11]
        snap_d.flags[isp_pkg::FLAG_F] = |i_warn_flags;        // [RULE12]
        snap_d.mag    = 16'h0000;
        if (layout_q && mag_q.valid) begin
          snap_d.flags[isp_pkg::FLAG_IDX_LO +: 2] = mag_q.axis; // [RULE10]
          snap_d.mag    = mag_q.value;                // [RULE9]
          mag_d.valid   = 1'b0;                       // [RULE8]
        end
        seq_d = seq_q + 8'h01;                        // [RULE20] [RULE24]
        if (seq_q == 8'hff) begin
          frame_d = frame_q + 16'h0001;               // [RULE3]
        end
        div_d    = (i_rate_divider < isp_pkg::DIV_MIN) ?
                   isp_pkg::DIV_MIN : i_rate_divider; // [RULE22]
        layout_d = i_layout_mag;                      // [RULE15]
      end
    end
    // fresh sample after consumption, so a same-cycle arrival wins
    if (i_mag_valid && (i_mag_axis != 2'h0)) begin
      mag_d = '{valid: 1'b1, axis: i_mag_axis, value: i_mag_value};
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_dv_q  <= '0;
      acc_dth_q <= '0;
      per_q     <= 8'h00;
      div_q     <= isp_pkg::DIV_RESET;
      seq_q     <= 8'h00;
      frame_q   <= 16'h0000;
      lat_q     <= 16'h0000;
      pre_q     <= '0;
      dly_q     <= 2'h0;
      layout_q  <= 1'b0;
      pend_q    <= 1'b0;
      drop_q    <= 1'b0;
      mag_q     <= '0;
      snap_q    <= '0;
    end else if (i_enable) begin
      acc_dv_q  <= acc_dv_d;
      acc_dth_q <= acc_dth_d;
      per_q     <= per_d;
      div_q     <= div_d;
      seq_q     <= seq_d;
      frame_q   <= frame_d;
      lat_q     <= lat_d;
      pre_q     <= pre_d;
      dly_q     <= dly_d;
      layout_q  <= layout_d;
      pend_q    <= pend_d;
      drop_q    <= drop_d;
      mag_q     <= mag_d;
      snap_q    <= snap_d;
    end
  end

  // ---------------------------------------------------------------
  // serialiser: one byte per cycle into the buffer, checksum last
  isp_pkg::isp_state_t st_d;
  isp_pkg::isp_pkt_t   cur_q, cur_d;
  logic [4:0]          idx_q, idx_d;
  logic [7:0]          sum_q, sum_d, tx_byte;
  logic                fifo_in_ready, last;

  always_comb begin
    st_d    = st_q;
    cur_d   = cur_q;
    idx_d   = idx_q;
    sum_d   = sum_q;
    last    = (idx_q == pkt_len(cur_q.ptype) - 5'h01); // [RULE17] [RULE23]
    tx_byte = last ? (8'h00 - sum_q)                  // [RULE21]
                   : pkt_byte(cur_q, idx_q);          // [RULE18]
    case (st_q)
      isp_pkg::ST_IDLE: begin
        if (launch) begin
          cur_d         = snap_q;
          cur_d.latency = lat_d;  // [RULE1]
          idx_d         = 5'h00;
          sum_d         = 8'h00;
          st_d          = isp_pkg::ST_SEND;
        end
      end
      isp_pkg::ST_SEND: begin
        if (fifo_in_ready) begin
          sum_d = sum_q + tx_byte;
          idx_d = idx_q + 5'h01;
          if (last) begin
            st_d = isp_pkg::ST_IDLE;
          end
        end
      end
      default: st_d = isp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q  <= isp_pkg::ST_IDLE;
      cur_q <= '0;
      idx_q <= 5'h00;
      sum_q <= 8'h00;
    end else if (i_enable) begin
      st_q  <= st_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      sum_q <= sum_d;
    end
  end

  // ---------------------------------------------------------------
  // byte buffer and registered output stage
  logic       fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic       obv_q, obv_d;
  logic [7:0] obd_q, obd_d;

  isp_fifo #(
    .W (8),
    .D (P_FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_arst_n    (i_arst_n),
    .i_enable    (i_enable),
    .i_in_valid  (st_q == isp_pkg::ST_SEND),
    .i_in_data   (tx_byte),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_out_ready)
  );

  assign fifo_out_ready = !obv_q || i_byte_ready;

  always_comb begin
    obv_d = obv_q;
    obd_d = obd_q;
    if (fifo_out_ready) begin
      obv_d = fifo_out_valid;
      obd_d = fifo_out_valid ? fifo_out_data : obd_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      obv_q <= 1'b0;
      obd_q <= 8'h00;
    end else if (i_enable) begin
      obv_q <= obv_d;
      obd_q <= obd_d;
    end
  end

  // outputs, all from flops
  assign o_byte_valid      = obv_q;
  assign o_byte_data       = obd_q;
  assign o_update_tick     = tick_q;
  assign o_packet_dropped  = drop_q; // [RULE24]
  assign o_packet_sequence = seq_q;
  assign o_frame_counter   = frame_q;

endmodule : isp_framer

//--- isp_framer_assertions.sv
// Purpose: port checks of the packet framer
// Assumes: one clock, asynchronous active-low reset, enable held high
// Notes:   byte position and running sum rebuilt from the byte stream
`timescale 1ns/10ps
module isp_framer_assertions #(
  parameter int P_TICK_CYCLES = 50
) (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  // byte stream and status
  input wire logic        o_byte_valid,
  input wire logic [7:0]  o_byte_data,
  input wire logic        i_byte_ready,
  input wire logic        o_update_tick,
  input wire logic        o_packet_dropped,
  input wire logic [7:0]  o_packet_sequence,
  input wire logic [15:0] o_frame_counter
);
  logic        acc;
  logic        last;
  logic [4:0]  idx_q, idx_d, len_q, len_d;
  logic [7:0]  sum_q, sum_d;
  logic [15:0] gap_q, gap_d;
  logic        seen_q, seen_d;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // byte taken, last byte of the packet
  assign acc  = o_byte_valid && i_byte_ready;
  assign last = (idx_q > 5'h02) && (idx_q == len_q - 5'h01);

  // position, length and sum of the packet in flight; tick spacing
  always_comb begin
    idx_d = idx_q;
    len_d = len_q;
    sum_d = sum_q;
    gap_d = o_update_tick ? 16'h0000 : gap_q + 16'h0001;
    seen_d = seen_q | o_update_tick;
    if (acc) begin
      idx_d = idx_q + 5'h01;
      sum_d = sum_q + o_byte_data;
      if (idx_q == 5'h01) begin
        len_d = (o_byte_data == isp_pkg::TYPE_MAG) ? isp_pkg::LEN_MAG
                                                   : isp_pkg::LEN_INC;
      end
      if (last) begin
        idx_d = 5'h00;
        sum_d = 8'h00;
      end
    end
  end

  // helper registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_q <= 5'h00;
      len_q <= isp_pkg::LEN_INC;
      sum_q <= 8'h00;
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      len_q <= len_d;
      sum_q <= sum_d;
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end

  sequence s_stall;
    o_byte_valid && !i_byte_ready;
  endsequence

  a_start_byte: assert property (
    acc && idx_q == 5'h00 |-> o_byte_data == isp_pkg::START_BYTE)
    else $error("packet does not open with the start byte");
  a_flag_reserved: assert property (
    acc && idx_q == 5'h03 |-> o_byte_data[7:5] == 3'h0 && !o_byte_data[2])
    else $error("reserved flag bits not zero");
  a_index_type3: assert property (
    acc && idx_q == 5'h03 && len_q == isp_pkg::LEN_INC |->
    o_byte_data[1:0] == 2'h0)
    else $error("increment layout carries a magnetometer index");
  a_checksum_zero: assert property (
    acc && last |-> sum_q + o_byte_data == 8'h00)
    else $error("packet bytes do not sum to zero");
  a_stall_hold: assert property (
    s_stall |=> o_byte_valid && $stable(o_byte_data))
    else $error("byte changed while stalled");
  a_seq_step: assert property (
    $changed(o_packet_sequence) |->
    o_packet_sequence == $past(o_packet_sequence) + 8'h01)
    else $error("sequence did not step by one");
  a_frame_wrap: assert property (
    $changed(o_packet_sequence) && o_packet_sequence == 8'h00 |->
    o_frame_counter == $past(o_frame_counter) + 16'h0001)
    else $error("frame counter did not advance on wrap");
  a_tick_spacing: assert property (
    o_update_tick && seen_q |-> gap_q == P_TICK_CYCLES - 1)
    else $error("update tick spacing wrong");
  a_launch_soon: assert property (
    $rose(o_byte_valid) && idx_q == 5'h00 |-> gap_q < 16'h0008)
    else $error("packet start not near an update tick");
  a_drop_busy: assert property (
    o_packet_dropped |-> o_byte_valid && gap_q < 16'h0004)
    else $error("drop reported while output idle");
endmodule : isp_framer_assertions

bind isp_framer isp_framer_assertions #(.P_TICK_CYCLES(P_TICK_CYCLES))
  i_isp_framer_assertions (
  .i_clock          (i_clock),
  .i_arst_n         (i_arst_n),
  .o_byte_valid     (o_byte_valid),
  .o_byte_data      (o_byte_data),
  .i_byte_ready     (i_byte_ready),
  .o_update_tick    (o_update_tick),
  .o_packet_dropped (o_packet_dropped),
  .o_packet_sequence(o_packet_sequence),
  .o_frame_counter  (o_frame_counter)
);

//--- isp_host_sink.sv
// Purpose: host side byte sink for the packet framer
// Assumes: a byte is taken on valid and ready at the rising edge
// Notes:   ready drops while the bench asks for a stall
`timescale 1ns/10ps
module isp_host_sink (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  // byte stream from the framer
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  // bench control
  input  wire logic       i_stall
);
  logic [7:0] rx_q[$];
  // ready follows the stall request
  assign o_ready = !i_stall;
  // accepted bytes queued in arrival order
  always @(posedge i_clock) begin
    if (i_arst_n && i_valid && o_ready) begin
      rx_q.push_back(i_data);
    end
  end
endmodule : isp_host_sink

//--- tb_isp_framer.sv
// Purpose: self-checking bench of the packet framer
// Assumes: short update tick of 60 cycles, inputs driven at falling edge
// Notes:   expectations follow from an exact half-scale diagonal plus a 0.5 cross term in align[6]
`timescale 1ns/10ps
module tb_isp_framer;
  localparam int TK = 60;
  logic clk, rst_n, stall, mag_v, layout, valid, ready, dropped, tick;
  logic [7:0] div, warn, bdata, seq, ls;
  logic [1:0] axis;
  logic [15:0] magv, frame, px;
  logic [8:0][15:0] align;
  logic [255:0] cfg;
  logic [2:0][23:0] dv, dth;
  logic [7:0] p[0:20];
  int n, c, n_errors, samples_checked, drops;

  isp_framer #(.P_TICK_CYCLES(TK)) i_isp_framer (
    .i_clock(clk), .i_arst_n(rst_n), .i_enable(1'b1),
    .i_rate_divider(div), .i_layout_mag(layout), .i_align(align),
    .i_config_bits(cfg), .i_warn_flags(warn), .i_dv_raw(dv),
    .i_dth_raw(dth), .i_mag_valid(mag_v), .i_mag_axis(axis),
    .i_mag_value(magv), .o_byte_valid(valid), .o_byte_data(bdata),
    .i_byte_ready(ready), .o_update_tick(tick),
    .o_packet_dropped(dropped), .o_packet_sequence(seq),
    .o_frame_counter(frame));
  isp_host_sink i_isp_host_sink (.i_clock(clk), .i_arst_n(rst_n),
    .i_valid(valid), .i_data(bdata), .o_ready(ready), .i_stall(stall));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // take one whole packet from the sink, length from the type byte
  task automatic recv;
    int w;
    for (w = 0; w < 3000; w++) begin
      @(negedge clk);
      n = 19;
      if (i_isp_host_sink.rx_q.size() > 1 &&
          i_isp_host_sink.rx_q[1] === isp_pkg::TYPE_MAG) n = 21;
      if (i_isp_host_sink.rx_q.size() >= n) break;
    end
    if (w == 3000) begin
      n_errors++;
      conclude();
    end
    for (int k = 0; k < n; k++) p[k] = i_isp_host_sink.rx_q.pop_front();
    ls = p[2];
    px = {p[13], p[12]};
  endtask : recv

  // full check of one packet against the previous one
  task automatic check_pkt(input logic [7:0] typ, input logic [7:0] flg,
                           input logic [7:0] step);
    logic [7:0] s, l;
    logic [15:0] x;
    l = ls;
    x = px;
    recv();
    s = 8'h00;
    for (int k = 0; k < n; k++) s += p[k];
    check(p[0], 8'ha5);
    check(p[1], typ);
    check(p[2], l + step);
    check(p[3], {flg[7:5], cfg[p[2]], flg[3:0]});
    check({p[5], p[4]}, 16'h0009);
    check({p[7], p[6]}, 16'h0004);
    check({p[9], p[8]}, 16'hfffc);
    check({p[11], p[10]}, 16'h0004);
    check({p[13], p[12]} + x, 16'h0001);
    check({p[15], p[14]}, {p[13], p[12]});
    check({p[17], p[16]}, 16'h0001);
    check(s, 8'h00);
  endtask : check_pkt

  task automatic wait_seq(output int cyc);
    logic [7:0] s0;
    s0 = seq;
    for (cyc = 0; cyc < 2000 && seq === s0; cyc++) @(negedge clk);
    if (seq === s0) begin
      n_errors++;
      conclude();
    end
  endtask : wait_seq

  initial begin
    {clk, rst_n, stall, mag_v, layout, axis, magv, warn} = '0;
    div = 8'h04;
    align = '0;
    align[0] = 16'h4000;
    align[4] = 16'h4000;
    align[6] = 16'h4000;
    align[8] = 16'h4000;
    cfg = {8{32'hc3a5_0f96}};
    dv = {24'h00_0000, 24'hff_fe00, 24'h00_0200};
    dth = {3{24'h00_0040}};
    {n_errors, samples_checked, drops} = '0;
    repeat (12) @(negedge clk);
    check({valid, tick, dropped, seq}, 16'h0000);
    check(frame, 16'h0000);
    rst_n = 1'b1;
    // test 1: packet rate
    wait_seq(c);
    check(c[15:0], 16'h012d);
    wait_seq(c);
    check(c[15:0], 16'h00f0);
    $display("test rate done");
    // test 2: increment layout contents and carried remainders
    recv();
    recv();
    repeat (5) check_pkt(isp_pkg::TYPE_INC, 8'h00, 8'h01);
    $display("test layout3 done");
    // test 3: warning flag
    warn = 8'h20;
    recv();
    check_pkt(isp_pkg::TYPE_INC, 8'h08, 8'h01);
    warn = 8'h00;
    $display("test fault done");
    // test 4: magnetometer layout, fresh then stale sample
    layout = 1'b1;
    repeat (3) recv();
    mag_v = 1'b1;
    axis = 2'h2;
    magv = 16'h1234;
    @(negedge clk);
    mag_v = 1'b0;
    check_pkt(isp_pkg::TYPE_MAG, 8'h02, 8'h01);
    check(n[15:0], 16'h0015);
    check({p[19], p[18]}, 16'h1234);
    check_pkt(isp_pkg::TYPE_MAG, 8'h00, 8'h01);
    check({p[19], p[18]}, 16'h0000);
    $display("test layout4 done");
    // test 5: host stall drops packets, numbering continues
    stall = 1'b1;
    for (c = 0; c < 2000 && drops < 2; c++) begin
      @(negedge clk);
      if (dropped === 1'b1) drops++;
    end
    stall = 1'b0;
    check(drops[15:0], 16'h0002);
    if (drops < 2) conclude();
    recv();
    check_pkt(isp_pkg::TYPE_MAG, 8'h00, 8'h03);
    $display("test drop done");
    // test 6: frame counter after a full frame
    for (c = 0; c < 70000 && frame !== 16'h0001; c++) @(negedge clk);
    check(frame, 16'h0001);
    check(seq, 8'h00);
    $display("test frame done");
    conclude();
  end
endmodule : tb_isp_framer
